// >>> hdl/dmcs_top.sv
// Drive monitor block: pulse counters, position, thermal estimate, two analog monitors.
// Assumes an AXI4-Lite master on aclk; feedback phases and sources come from aclk logic.
//
// Notes on behaviour
// - Every pulse on the command pulse input adds one to a readable counter; here pulses shorter than two aclk cycles are not counted.
// - A clear request zeroes the command pulse counter, which then counts on from zero.
// - A second counter adds every rising edge of feedback phase A or B.
// - The feedback edge counter can be cleared to zero and then counts on.
// - The present position is readable, in pulse units.
// - A thermal estimate follows motor current and raises a warning above a threshold.
// - The thermal readout lies in 0 to 100 percent, nonzero meaning above rated torque.
// - Each channel selector picks presets 0 to 8 or another monitor code.
// - Each analog channel spans zero to five volts with 2.5 volts at center.
// - The offset sits at center and one range of deviation gives plus 2.5 volts.
// - A monitored input function shows its state after polarity and filtering.
// - A monitored output function shows its state before stability filter and inversion.
// - A function state with range one and offset zero gives 5 V active, 2.5 V idle.
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dmcs_params.svh"
module dmcs_top #(
   parameter int CNT_W          = 32,
   parameter int DAC_W          = 12,
   parameter int THERM_TICK_CYC = `DMCS_THERM_TICK_CYC,
   parameter int RATED_CURRENT  = 1000
) (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output var  logic                 s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output var  logic                 s_axi_wready,
   output var  logic [1:0]           s_axi_bresp,
   output var  logic                 s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output var  logic                 s_axi_arready,
   output var  logic [31:0]          s_axi_rdata,
   output var  logic [1:0]           s_axi_rresp,
   output var  logic                 s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire logic                 cmd_pulse_in,
   input  wire logic                 fb_phase_a,
   input  wire logic                 fb_phase_b,
   input  wire dmcs_pkg::dmcs_word_t position_in,
   input  wire logic signed [15:0]   motor_current,
   input  wire dmcs_pkg::dmcs_word_t actual_velocity,
   input  wire dmcs_pkg::dmcs_word_t commanded_velocity,
   input  wire dmcs_pkg::dmcs_word_t velocity_error,
   input  wire dmcs_pkg::dmcs_word_t torque_command,
   input  wire dmcs_pkg::dmcs_word_t phase_u_current,
   input  wire dmcs_pkg::dmcs_word_t position_command_rate,
   input  wire dmcs_pkg::dmcs_word_t position_error,
   input  wire dmcs_pkg::dmcs_word_t pulse_quantity,
   input  wire logic [15:0]          input_fn_state,
   input  wire logic [15:0]          output_fn_state,
   output var  logic                 thermal_overload_warning,
   output var  logic                 irq,
   output var  logic [DAC_W-1:0]     analog_out_one,
   output var  logic [DAC_W-1:0]     analog_out_two
);
   localparam logic [31:0] RATED_SQ = 32'(RATED_CURRENT * RATED_CURRENT);
   localparam int TW = $clog2(THERM_TICK_CYC + 1);

   // Bus registers
   logic [7:0]                  awaddr_reg;
   logic [31:0]                 wdata_reg;
   logic [3:0]                  wstrb_reg;
   logic                        wr_do;
   logic [31:0]                 rdata_next;
   logic                        rd_hit;
   logic                        wr_hit;
   logic [31:0]                 wmask;

   // Software state
   logic [31:0]                 thresh_reg;
   logic [7:0]                  sel_reg [2];
   dmcs_pkg::dmcs_word_t        span_reg [2];
   dmcs_pkg::dmcs_word_t        center_reg [2];
   logic [`DMCS_IRQ_BITS-1:0]   irq_status_reg;
   logic [`DMCS_IRQ_BITS-1:0]   irq_mask_reg;
   logic [`DMCS_IRQ_BITS-1:0]   irq_event;
   logic                        clr_cmd;
   logic                        clr_fb;

   // Block state
   logic [2:0]                  cmd_sync_reg;
   logic                        cmd_level_reg;
   logic                        cmd_rise;
   logic [CNT_W-1:0]            cmd_count_reg;
   logic                        fb_a_reg;
   logic                        fb_b_reg;
   logic [1:0]                  fb_edges;
   logic [CNT_W-1:0]            fb_count_reg;
   logic [CNT_W:0]              fb_sum;
   dmcs_pkg::dmcs_word_t        position_reg;
   logic [13:0]                 thermal_reg;
   logic [TW-1:0]               tick_cnt_reg;
   logic [31:0]                 cur_sq;
   dmcs_pkg::dmcs_word_t        mon_data [2];

   assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   assign wr_do = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

   // Write address and data are taken independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `DMCS_RESP_OKAY;
         awaddr_reg    <= 8'h00;
         wdata_reg     <= 32'h0000_0000;
         wstrb_reg     <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            awaddr_reg    <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
         end
         if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `DMCS_RESP_OKAY : `DMCS_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_comb begin
      case (awaddr_reg)
         `DMCS_OFF_CTRL, `DMCS_OFF_THRESH, `DMCS_OFF_CH1_SEL, `DMCS_OFF_CH1_SPAN,
         `DMCS_OFF_CH1_CENTER, `DMCS_OFF_CH2_SEL, `DMCS_OFF_CH2_SPAN,
         `DMCS_OFF_CH2_CENTER, `DMCS_OFF_IRQ_STATUS, `DMCS_OFF_IRQ_MASK: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   assign clr_cmd = wr_do && awaddr_reg == `DMCS_OFF_CTRL && wstrb_reg[0]
                    && wdata_reg[`DMCS_CTRL_CLR_CMD];
   assign clr_fb  = wr_do && awaddr_reg == `DMCS_OFF_CTRL && wstrb_reg[0]
                    && wdata_reg[`DMCS_CTRL_CLR_FB];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         thresh_reg    <= `DMCS_RST_THRESH;
         sel_reg[0]    <= `DMCS_RST_SEL;
         sel_reg[1]    <= `DMCS_RST_SEL;
         span_reg[0]   <= `DMCS_RST_SPAN;
         span_reg[1]   <= `DMCS_RST_SPAN;
         center_reg[0] <= `DMCS_RST_CENTER;
         center_reg[1] <= `DMCS_RST_CENTER;
         irq_mask_reg  <= `DMCS_RST_MASK;
      end else if (wr_do) begin
         case (awaddr_reg)
            `DMCS_OFF_THRESH:     thresh_reg    <= (thresh_reg & ~wmask) | (wdata_reg & wmask);
            `DMCS_OFF_CH1_SEL: begin
               if (wstrb_reg[0]) begin
                  sel_reg[0] <= wdata_reg[7:0];
               end
            end
            `DMCS_OFF_CH2_SEL: begin
               if (wstrb_reg[0]) begin
                  sel_reg[1] <= wdata_reg[7:0];
               end
            end
            `DMCS_OFF_CH1_SPAN:   span_reg[0]   <= (span_reg[0] & ~wmask) | (wdata_reg & wmask);
            `DMCS_OFF_CH2_SPAN:   span_reg[1]   <= (span_reg[1] & ~wmask) | (wdata_reg & wmask);
            `DMCS_OFF_CH1_CENTER: center_reg[0] <= (center_reg[0] & ~wmask) | (wdata_reg & wmask);
            `DMCS_OFF_CH2_CENTER: center_reg[1] <= (center_reg[1] & ~wmask) | (wdata_reg & wmask);
            `DMCS_OFF_IRQ_MASK: begin
               if (wstrb_reg[0]) begin
                  irq_mask_reg <= wdata_reg[`DMCS_IRQ_BITS-1:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Read side: one read at a time, data captured at the address handshake
   always_comb begin
      rd_hit = 1'b1;
      case (s_axi_araddr)
         `DMCS_OFF_CTRL:       rdata_next = 32'h0000_0000;
         `DMCS_OFF_CMD_COUNT:  rdata_next = 32'(cmd_count_reg);
         `DMCS_OFF_FB_COUNT:   rdata_next = 32'(fb_count_reg);
         `DMCS_OFF_POSITION:   rdata_next = position_reg;
         `DMCS_OFF_THERMAL:    rdata_next = {18'h0, thermal_reg};
         `DMCS_OFF_THRESH:     rdata_next = thresh_reg;
         `DMCS_OFF_CH1_SEL:    rdata_next = {24'h0, sel_reg[0]};
         `DMCS_OFF_CH1_SPAN:   rdata_next = span_reg[0];
         `DMCS_OFF_CH1_CENTER: rdata_next = center_reg[0];
         `DMCS_OFF_CH2_SEL:    rdata_next = {24'h0, sel_reg[1]};
         `DMCS_OFF_CH2_SPAN:   rdata_next = span_reg[1];
         `DMCS_OFF_CH2_CENTER: rdata_next = center_reg[1];
         `DMCS_OFF_IRQ_STATUS: rdata_next = {29'h0, irq_status_reg};
         `DMCS_OFF_IRQ_MASK:   rdata_next = {29'h0, irq_mask_reg};
         default: begin
            rdata_next = 32'h0000_0000;
            rd_hit     = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `DMCS_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdata_next;
            s_axi_rresp   <= rd_hit ? `DMCS_RESP_OKAY : `DMCS_RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Command pulse pin: a rise to high counts once the last two stages agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_sync_reg  <= 3'h0;
         cmd_level_reg <= 1'b0;
      end else begin
         cmd_sync_reg <= {cmd_sync_reg[1:0], cmd_pulse_in};
         if (cmd_sync_reg[1] == cmd_sync_reg[2]) begin
            cmd_level_reg <= cmd_sync_reg[2];
         end
      end
   end
   assign cmd_rise = !cmd_level_reg && cmd_sync_reg[1] && cmd_sync_reg[2];

   // A pulse in the clearing cycle is kept, so the count restarts at one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_count_reg <= '0;
      end else if (clr_cmd) begin
         cmd_count_reg <= CNT_W'(cmd_rise);
      end else if (cmd_rise) begin
         cmd_count_reg <= cmd_count_reg + 1'b1;
      end
   end

   // Feedback phases are internal to this clock, so no synchroniser
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fb_a_reg <= 1'b0;
         fb_b_reg <= 1'b0;
      end else begin
         fb_a_reg <= fb_phase_a;
         fb_b_reg <= fb_phase_b;
      end
   end
   assign fb_edges = 2'(fb_phase_a && !fb_a_reg) + 2'(fb_phase_b && !fb_b_reg);
   assign fb_sum   = {1'b0, fb_count_reg} + (CNT_W+1)'(fb_edges);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fb_count_reg <= '0;
      end else if (clr_fb) begin
         fb_count_reg <= CNT_W'(fb_edges);
      end else begin
         fb_count_reg <= fb_sum[CNT_W-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         position_reg <= 32'h0000_0000;
      end else begin
         position_reg <= position_in;
      end
   end

   // Heat rises while current exceeds rated, radiates otherwise; 0.01 % steps
   assign cur_sq = 32'(motor_current * motor_current);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt_reg <= '0;
         thermal_reg  <= 14'h0000;
      end else if (tick_cnt_reg == TW'(THERM_TICK_CYC - 1)) begin
         tick_cnt_reg <= '0;
         if (cur_sq > RATED_SQ) begin
            if (thermal_reg < `DMCS_THERM_FULL) begin
               thermal_reg <= thermal_reg + 14'h0001;
            end
         end else if (thermal_reg != 14'h0000) begin
            thermal_reg <= thermal_reg - 14'h0001;
         end
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         thermal_overload_warning <= 1'b0;
      end else begin
         thermal_overload_warning <= 32'(thermal_reg) > thresh_reg;
      end
   end

   assign irq_event[`DMCS_IRQ_WARN]     = (32'(thermal_reg) > thresh_reg)
                                          && !thermal_overload_warning;
   assign irq_event[`DMCS_IRQ_CMD_WRAP] = cmd_rise && (&cmd_count_reg) && !clr_cmd;
   assign irq_event[`DMCS_IRQ_FB_WRAP]  = fb_sum[CNT_W] && !clr_fb;

   // A new event wins over a write-one clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_reg <= '0;
         irq <= 1'b0;
      end else begin
         if (wr_do && awaddr_reg == `DMCS_OFF_IRQ_STATUS && wstrb_reg[0]) begin
            irq_status_reg <= (irq_status_reg & ~wdata_reg[`DMCS_IRQ_BITS-1:0]) | irq_event;
         end else begin
            irq_status_reg <= irq_status_reg | irq_event;
         end
         irq <= |(irq_status_reg & irq_mask_reg);
      end
   end

   // Per channel source select; function states are 0 or 1 in plain units
   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      always_comb begin
         mon_data[ch] = 32'sh0000_0000;
         case (sel_reg[ch])
            dmcs_pkg::DMCS_MON_VEL_ACT:   mon_data[ch] = actual_velocity;
            dmcs_pkg::DMCS_MON_VEL_CMD:   mon_data[ch] = commanded_velocity;
            dmcs_pkg::DMCS_MON_VEL_ERR:   mon_data[ch] = velocity_error;
            dmcs_pkg::DMCS_MON_TORQUE:    mon_data[ch] = torque_command;
            dmcs_pkg::DMCS_MON_CUR_U:     mon_data[ch] = phase_u_current;
            dmcs_pkg::DMCS_MON_POS_RATE:  mon_data[ch] = position_command_rate;
            dmcs_pkg::DMCS_MON_POS_ERR:   mon_data[ch] = position_error;
            dmcs_pkg::DMCS_MON_PULSE_QTY: mon_data[ch] = pulse_quantity;
            dmcs_pkg::DMCS_MON_THERMAL:   mon_data[ch] = 32'(thermal_reg);
            dmcs_pkg::DMCS_MON_CMD_COUNT: mon_data[ch] = 32'(cmd_count_reg);
            dmcs_pkg::DMCS_MON_FB_COUNT:  mon_data[ch] = 32'(fb_count_reg);
            dmcs_pkg::DMCS_MON_POSITION:  mon_data[ch] = position_reg;
            default: begin
               if (sel_reg[ch][7:4] == 4'h1) begin
                  mon_data[ch] = 32'(input_fn_state[sel_reg[ch][3:0]]);
               end else if (sel_reg[ch][7:4] == 4'h2) begin
                  mon_data[ch] = 32'(output_fn_state[sel_reg[ch][3:0]]);
               end
            end
         endcase
      end
   end

   dmcs_scaler #(.DAC_W(DAC_W)) u_scale_one (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .data     (mon_data[0]),
      .span     (span_reg[0]),
      .center   (center_reg[0]),
      .code_reg (analog_out_one)
   );

   dmcs_scaler #(.DAC_W(DAC_W)) u_scale_two (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .data     (mon_data[1]),
      .span     (span_reg[1]),
      .center   (center_reg[1]),
      .code_reg (analog_out_two)
   );
endmodule
`default_nettype wire

// >>> hdl/dmcs_params.svh
// Offsets, field positions, reset values and timing counts of the monitor block.
// Assumes inclusion by bare name from design files.
`ifndef DMCS_PARAMS_SVH
`define DMCS_PARAMS_SVH

`define DMCS_OFF_CTRL        8'h00
`define DMCS_OFF_CMD_COUNT   8'h04
`define DMCS_OFF_FB_COUNT    8'h08
`define DMCS_OFF_POSITION    8'h0C
`define DMCS_OFF_THERMAL     8'h10
`define DMCS_OFF_THRESH      8'h14
`define DMCS_OFF_CH1_SEL     8'h18
`define DMCS_OFF_CH1_SPAN    8'h1C
`define DMCS_OFF_CH1_CENTER  8'h20
`define DMCS_OFF_CH2_SEL     8'h24
`define DMCS_OFF_CH2_SPAN    8'h28
`define DMCS_OFF_CH2_CENTER  8'h2C
`define DMCS_OFF_IRQ_STATUS  8'h30
`define DMCS_OFF_IRQ_MASK    8'h34

`define DMCS_CTRL_CLR_CMD    0
`define DMCS_CTRL_CLR_FB     1
`define DMCS_IRQ_WARN        0
`define DMCS_IRQ_CMD_WRAP    1
`define DMCS_IRQ_FB_WRAP     2
`define DMCS_IRQ_BITS        3

`define DMCS_RST_SEL         8'h00
`define DMCS_RST_SPAN        32'h0000_2710
`define DMCS_RST_CENTER      32'h0000_0000
`define DMCS_RST_THRESH      32'h0000_1F40
`define DMCS_RST_MASK        3'h0

`define DMCS_THERM_FULL      14'h2710
`define DMCS_CLK_HZ          50000000
`define DMCS_THERM_TICK_US   1000
`define DMCS_THERM_TICK_CYC  ((`DMCS_CLK_HZ / 1000000) * `DMCS_THERM_TICK_US)

`define DMCS_RESP_OKAY       2'h0
`define DMCS_RESP_SLVERR     2'h2

`endif

// >>> hdl/dmcs_pkg.sv
// Types shared by the monitor block files.
// Assumes dmcs_params.svh supplies the numeric constants.
package dmcs_pkg;
   typedef enum logic [7:0] {
      DMCS_MON_VEL_ACT   = 8'h00,
      DMCS_MON_VEL_CMD   = 8'h01,
      DMCS_MON_VEL_ERR   = 8'h02,
      DMCS_MON_TORQUE    = 8'h03,
      DMCS_MON_CUR_U     = 8'h04,
      DMCS_MON_POS_RATE  = 8'h05,
      DMCS_MON_POS_ERR   = 8'h06,
      DMCS_MON_PULSE_QTY = 8'h07,
      DMCS_MON_THERMAL   = 8'h08,
      DMCS_MON_CMD_COUNT = 8'h30,
      DMCS_MON_FB_COUNT  = 8'h31,
      DMCS_MON_POSITION  = 8'h32
   } dmcs_mon_t;
   typedef logic signed [31:0] dmcs_word_t;
endpackage

// >>> hdl/dmcs_scaler.sv
// One analog monitor channel: maps a monitored value to an output code.
// Assumes code 0 is 0 V, full code is 5 V, half code is 2.5 V.
`timescale 1ns/1ps
`default_nettype none
module dmcs_scaler #(
   parameter int DAC_W = 12
) (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire dmcs_pkg::dmcs_word_t data,
   input  wire dmcs_pkg::dmcs_word_t span,
   input  wire dmcs_pkg::dmcs_word_t center,
   output var  logic [DAC_W-1:0]     code_reg
);
   localparam logic signed [63:0] HALF = 64'sd1 <<< (DAC_W - 1);
   localparam logic signed [63:0] TOP  = (64'sd1 <<< DAC_W) - 64'sd1;

   logic signed [63:0] diff;
   logic signed [63:0] quot;
   logic signed [63:0] level;
   logic [DAC_W-1:0]   code_next;

   always_comb begin
      diff = 64'(data) - 64'(center);
      // Offset lands on half scale, one span away lands on full scale
      quot = (span > 0) ? (diff * HALF) / 64'(span) : 64'sd0;
      level = HALF + quot;
      if (level < 0) begin
         code_next = '0;
      end else if (level > TOP) begin
         code_next = TOP[DAC_W-1:0];
      end else begin
         code_next = level[DAC_W-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         code_reg <= HALF[DAC_W-1:0];
      end else begin
         code_reg <= code_next;
      end
   end
endmodule
`default_nettype wire

// >>> dv/dmcs_top_asserts.sv
// Checker on the monitor block ports, bound into dmcs_top.
// Assumes one clock domain, aclk, with synchronous active-low aresetn.
`timescale 1ns/1ps
`default_nettype none
module dmcs_top_asserts #(
   parameter int DAC_W = 12
) (
   input wire logic             aclk,
   input wire logic             aresetn,
   input wire logic             s_axi_awvalid,
   input wire logic             s_axi_awready,
   input wire logic             s_axi_wvalid,
   input wire logic             s_axi_wready,
   input wire logic             s_axi_bvalid,
   input wire logic             s_axi_bready,
   input wire logic [1:0]       s_axi_bresp,
   input wire logic [7:0]       s_axi_araddr,
   input wire logic             s_axi_arvalid,
   input wire logic             s_axi_arready,
   input wire logic             s_axi_rvalid,
   input wire logic             s_axi_rready,
   input wire logic [31:0]      s_axi_rdata,
   input wire logic [1:0]       s_axi_rresp,
   input wire logic             irq,
   input wire logic             thermal_overload_warning,
   input wire logic [DAC_W-1:0] analog_out_one
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   wr_resp_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   rd_resp_a: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read answer late");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
   r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answering");
   unmapped_rd_a: assert property (rd_taken and s_axi_araddr > 8'h34 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read answered");
   reset_out_a: assert property ($rose(aresetn) |-> analog_out_one == (1 << (DAC_W-1)) && !irq && !thermal_overload_warning)
      else $error("outputs not idle after reset");
endmodule
bind dmcs_top dmcs_top_asserts #(.DAC_W(DAC_W)) u_chk (.*);
`default_nettype wire

// >>> dv/dmcs_host.sv
// Host side model: register master over the lite bus.
// Assumes the bench calls wr and rd one at a time; resp 3 marks a timeout.
`timescale 1ns/1ps
`default_nettype none
module dmcs_host (
   input wire logic         aclk,
   output var logic [7:0]   s_axi_awaddr,
   output var logic         s_axi_awvalid,
   input wire logic         s_axi_awready,
   output var logic [31:0]  s_axi_wdata,
   output var logic [3:0]   s_axi_wstrb,
   output var logic         s_axi_wvalid,
   input wire logic         s_axi_wready,
   input wire logic [1:0]   s_axi_bresp,
   input wire logic         s_axi_bvalid,
   output var logic         s_axi_bready,
   output var logic [7:0]   s_axi_araddr,
   output var logic         s_axi_arvalid,
   input wire logic         s_axi_arready,
   input wire logic [31:0]  s_axi_rdata,
   input wire logic [1:0]   s_axi_rresp,
   input wire logic         s_axi_rvalid,
   output var logic         s_axi_rready
);
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end
   task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      r = 2'h3;
      for (n = 0; n < 200; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
      // One idle edge so no strobe is driven twice in one step
      @(posedge aclk);
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      r = 2'h3;
      d = 32'h0;
      for (n = 0; n < 200; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
      @(posedge aclk);
   endtask
endmodule
`default_nettype wire

// >>> dv/drive_monitor_counters_scaler_tb_top.sv
// Self-checking bench for the monitor block.
// Assumes a short thermal tick; all inputs change by non-blocking assignment at aclk.
`timescale 1ns/1ps
`default_nettype none
module drive_monitor_counters_scaler_tb_top;
   logic aclk = 0, aresetn = 0, cmd_pulse_in = 0, fb_phase_a = 0, fb_phase_b = 0;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, thermal_overload_warning;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, q;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   dmcs_pkg::dmcs_word_t position_in = 0, actual_velocity = 1000, commanded_velocity = 2000;
   dmcs_pkg::dmcs_word_t velocity_error = 3000, torque_command = 4000, phase_u_current = 5000;
   dmcs_pkg::dmcs_word_t position_command_rate = 6000, position_error = 7000, pulse_quantity = 8000;
   logic signed [15:0] motor_current = 0;
   logic [15:0] input_fn_state = 0, output_fn_state = 0;
   logic [11:0] analog_out_one, analog_out_two;
   int fail_count = 0, total_checks = 0, n;
   always #10 aclk = ~aclk;
   dmcs_top #(.THERM_TICK_CYC(4)) u_dut (.*);
   dmcs_host u_host (.*);
   task results;
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task to_chk;
      if (r === 2'h3) begin
         fail_count++;
         results;
      end
   endtask
   task w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      u_host.wr(a, d, r);
      to_chk;
      chk(r, er);
   endtask
   task rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      u_host.rd(a, q, r);
      to_chk;
      chk(r, er);
      chk(q, e);
   endtask
   task wt(input int k);
      repeat (k) @(posedge aclk);
   endtask
   task pulses(input int k);
      // Three cycles each level clears the input synchroniser
      repeat (k) begin
         cmd_pulse_in <= 1'b1;
         wt(3);
         cmd_pulse_in <= 1'b0;
         wt(3);
      end
      wt(8);
   endtask
   task t_regs;
      rc(8'h18, 32'h0, 2'h0);
      rc(8'h1C, 32'h2710, 2'h0);
      rc(8'h20, 32'h0, 2'h0);
      rc(8'h14, 32'h1F40, 2'h0);
      rc(8'h3C, 32'h0, 2'h2);
      w(8'h04, 32'h7, 2'h2);
   endtask
   task t_counts;
      pulses(5);
      rc(8'h04, 32'h5, 2'h0);
      w(8'h00, 32'h1, 2'h0);
      rc(8'h04, 32'h0, 2'h0);
      pulses(2);
      rc(8'h04, 32'h2, 2'h0);
      fb_phase_a <= 1'b1;
      wt(1);
      fb_phase_b <= 1'b1;
      wt(1);
      {fb_phase_a, fb_phase_b} <= 2'h0;
      wt(1);
      {fb_phase_a, fb_phase_b} <= 2'h3;
      wt(2);
      rc(8'h08, 32'h4, 2'h0);
      w(8'h00, 32'h2, 2'h0);
      rc(8'h08, 32'h0, 2'h0);
      rc(8'h04, 32'h2, 2'h0);
      position_in <= -100;
      wt(3);
      rc(8'h0C, 32'hFFFF_FF9C, 2'h0);
   endtask
   task t_therm;
      w(8'h14, 32'h2, 2'h0);
      w(8'h34, 32'h1, 2'h0);
      motor_current <= 16'sh07D0;
      for (n = 0; n < 300 && thermal_overload_warning !== 1'b1; n++) wt(1);
      if (n == 300) r = 2'h3;
      to_chk;
      wt(3);
      chk(irq, 1'b1);
      u_host.rd(8'h10, q, r);
      to_chk;
      chk(q > 32'h0 && q <= 32'h2710, 1'b1);
      motor_current <= 16'sh0000;
      wt(400);
      rc(8'h10, 32'h0, 2'h0);
      chk(thermal_overload_warning, 1'b0);
      w(8'h30, 32'h1, 2'h0);
      wt(2);
      chk(irq, 1'b0);
   endtask
   task t_analog;
      chk(analog_out_two, 12'h8CC);
      for (n = 0; n <= 8; n++) begin
         w(8'h18, n, 2'h0);
         wt(3);
         chk(analog_out_one, n < 8 ? 2048 + (n + 1) * 1000 * 2048 / 10000 : 2048);
      end
      w(8'h1C, 32'h1, 2'h0);
      w(8'h18, 32'h13, 2'h0);
      input_fn_state <= 16'h0008;
      wt(3);
      chk(analog_out_one, 12'hFFF);
      input_fn_state <= 16'h0000;
      wt(3);
      chk(analog_out_one, 12'h800);
      w(8'h18, 32'h30, 2'h0);
      wt(3);
      chk(analog_out_one, 12'hFFF);
      w(8'h28, 32'h1, 2'h0);
      w(8'h24, 32'h25, 2'h0);
      output_fn_state <= 16'h0020;
      wt(3);
      chk(analog_out_two, 12'hFFF);
      output_fn_state <= 16'h0000;
      w(8'h2C, 32'h5, 2'h0);
      wt(3);
      chk(analog_out_two, 12'h000);
   endtask
   initial begin
      wt(4);
      aresetn <= 1'b1;
      wt(1);
      t_regs;
      t_counts;
      t_therm;
      t_analog;
      results;
   end
endmodule
`default_nettype wire
